// [verilog/ssu_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
module ssu_serial_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rdata_valid,
    // serial link
    input wire logic rx_serial_clock_pin,
    input wire logic rx_frame_sync_pin,
    input wire logic rx_serial_data_pin,
    output logic tx_serial_data_pin,
    // dual purpose pins
    input wire logic dual_pin_one_in,
    output logic dual_pin_one_out,
    output logic dual_pin_one_oe_n,
    input wire logic dual_pin_two_in,
    output logic dual_pin_two_out,
    output logic dual_pin_two_oe_n,
    // change detector request
    output logic change_detect_request
);
    logic [31:0] ctl_q;
    logic halve_q, change_q, underrun_q, overrun_q;
    logic pin1_prev_q, half_clk_q, tx_clk_prev_q, rx_clk_prev_q;
    logic [3:0] gen_bit_q, gen_slot_q;
    logic gen_fs_q;
    ssu_pkg::ssu_tx_state_t tx_state_q;
    logic [15:0] tx_sr_q, tx_last_q;
    logic [3:0] tx_cnt_q, rx_cnt_q;
    logic [15:0] rx_sr_q;
    logic rx_active_q;
    logic pend_q;
    logic [15:0] pend_data_q;
    logic pin1_out_q, pin2_out_q, pin1_oe_n_q, pin2_oe_n_q;

    ssu_fifo_if tx_if ();
    ssu_fifo_if rx_if ();

    function automatic logic first_bit(input logic [15:0] w, input logic lsb);
        return lsb ? w[0] : w[15];
    endfunction : first_bit

    function automatic logic [15:0] shift_out(input logic [15:0] w, input logic lsb);
        return lsb ? {1'b0, w[15:1]} : {w[14:0], 1'b0};
    endfunction : shift_out

    // register decode
    wire wr_ctl = reg_write && (reg_addr == ssu_pkg::OFF_CTL);
    wire wr_csr = reg_write && (reg_addr == ssu_pkg::OFF_CSR);
    wire wr_txdr = reg_write && (reg_addr == ssu_pkg::OFF_TXDR);
    wire wr_ack = reg_write && (reg_addr == ssu_pkg::OFF_RXACK);
    wire soft_all = wr_ctl && reg_wdata[ssu_pkg::CTL_TXR] && reg_wdata[ssu_pkg::CTL_RXR];
    wire core_rst = srst || soft_all;

    // control fields, own clock polarity and shift direction for each direction
    wire [1:0] pin1_sel = ctl_q[ssu_pkg::CTL_PIN1_SEL +: 2];
    wire [1:0] pin2_sel = ctl_q[ssu_pkg::CTL_PIN2_SEL +: 2];
    wire frame_pulse_mode = ctl_q[ssu_pkg::CTL_FMS];
    wire tx_clock_polarity = ctl_q[ssu_pkg::CTL_TCP];
    wire rx_clock_polarity = ctl_q[ssu_pkg::CTL_RCP];
    wire tx_shift_direction = ctl_q[ssu_pkg::CTL_TSD];
    wire rx_shift_direction = ctl_q[ssu_pkg::CTL_RSD];
    wire [3:0] slots = ctl_q[ssu_pkg::CTL_SLOTS +: 4];
    wire transmitter_enable = ctl_q[ssu_pkg::CTL_TXE];
    wire rxe = ctl_q[ssu_pkg::CTL_RXE];
    wire ems = ctl_q[ssu_pkg::CTL_EMS];

    // halved receive clock as transmit base
    wire base_clk = halve_q ? half_clk_q : rx_serial_clock_pin;
    wire tx_clk = (pin1_sel == ssu_pkg::SEL_FUNC_A) ? dual_pin_one_in : base_clk;
    wire tx_edge = tx_clock_polarity ? (tx_clk_prev_q && !tx_clk) : (!tx_clk_prev_q && tx_clk);
    // receive clock straight from its pin
    wire rx_rise = !rx_clk_prev_q && rx_serial_clock_pin;
    wire rx_edge = rx_clock_polarity ? (rx_clk_prev_q && !rx_serial_clock_pin) : rx_rise;

    wire [3:0] slot_last = slots - 4'h1;
    // word or bit long sync pulse
    wire gen_fs_d = (gen_slot_q == 4'h0) && (!frame_pulse_mode || gen_bit_q == 4'h0);

    wire tx_fs = (pin2_sel == ssu_pkg::SEL_FUNC_A) ? gen_fs_q :
                 (pin2_sel == ssu_pkg::SEL_FUNC_B) ? dual_pin_two_in : rx_frame_sync_pin;

    // reload word, previous one when buffer is dry
    wire tx_dry = tx_if.empty;
    wire [15:0] tx_load = tx_dry ? tx_last_q : tx_if.head0;
    wire tx_reload = transmitter_enable && tx_edge && (((tx_state_q == ssu_pkg::TX_IDLE) && tx_fs) ||
                     ((tx_state_q == ssu_pkg::TX_SHIFT) && (tx_cnt_q == 4'h0)));

    // split transmit word, order by endian bit
    wire [5:0] tx_used = tx_if.count + {5'h00, pend_q};
    wire txdr_ok = wr_txdr && (tx_used <= 6'(ssu_pkg::TX_DEPTH - 2));
    wire [15:0] tx_first = ems ? reg_wdata[15:0] : reg_wdata[31:16];
    wire [15:0] tx_second = ems ? reg_wdata[31:16] : reg_wdata[15:0];
    assign tx_if.push = pend_q || txdr_ok;
    assign tx_if.push_data = pend_q ? pend_data_q : tx_first;
    assign tx_if.pop = tx_reload && !tx_dry;
    assign tx_if.pop2 = 1'b0;

    wire [15:0] rx_next = rx_shift_direction ? {rx_serial_data_pin, rx_sr_q[15:1]} :
                                {rx_sr_q[14:0], rx_serial_data_pin};
    wire rx_take = rxe && rx_edge && (rx_active_q || rx_frame_sync_pin);
    wire rx_done = rx_take && (rx_active_q ? rx_cnt_q : 4'h0) == ssu_pkg::BIT_LAST;
    wire rx_overrun_ev = rx_done && rx_if.full;
    assign rx_if.push = rx_done && !rx_if.full;
    assign rx_if.push_data = rx_next;
    assign rx_if.pop = 1'b0;
    assign rx_if.pop2 = wr_ack && reg_wdata[0];

    // change detector on pin one input
    wire change_ev = (pin1_sel == ssu_pkg::SEL_GP_IN) && (pin1_prev_q != dual_pin_one_in);
    assign change_detect_request = change_q && ctl_q[ssu_pkg::CTL_CDE];

    wire [4:0] words_available_read = rx_if.count[5:1];
    wire [5:0] tx_free = 6'(ssu_pkg::TX_DEPTH) - tx_if.count;
    // receive word read without side effect
    wire [31:0] rxdr = ems ? {rx_if.head1, rx_if.head0} : {rx_if.head0, rx_if.head1};
    wire [31:0] csr_view = {10'h000, tx_free, 3'h0, words_available_read, 2'h0, overrun_q, underrun_q,
                            change_q, dual_pin_two_in, dual_pin_one_in, halve_q};
    wire [31:0] rd_mux = (reg_addr == ssu_pkg::OFF_CTL) ? ctl_q :
                         (reg_addr == ssu_pkg::OFF_CSR) ? csr_view :
                         (reg_addr == ssu_pkg::OFF_RXDR) ? rxdr : 32'h00000000;

    ssu_word_fifo #(.DEPTH(ssu_pkg::TX_DEPTH)) u_tx_buf (
        .ref_clk(ref_clk),
        .srst(core_rst),
        .port(tx_if.store)
    );

    ssu_word_fifo #(.DEPTH(ssu_pkg::RX_DEPTH)) u_rx_buf (
        .ref_clk(ref_clk),
        .srst(core_rst),
        .port(rx_if.store)
    );

    // control register
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            ctl_q <= ssu_pkg::CTL_RESET;
        end else if (wr_ctl) begin
            ctl_q <= reg_wdata & ssu_pkg::CTL_STORE_MASK;
            if (reg_wdata[ssu_pkg::CTL_TXR]) begin
                ctl_q[ssu_pkg::CTL_PIN1_SEL +: 2] <= ssu_pkg::SEL_FUNC_B;
                ctl_q[ssu_pkg::CTL_PIN2_SEL +: 2] <= ssu_pkg::SEL_FUNC_B;
            end
        end
    end

    // status flags, hardware set wins over write-one clear
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            halve_q <= ssu_pkg::CSR_HALVE_RESET;
            change_q <= 1'b0;
            underrun_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            if (wr_csr) begin
                halve_q <= reg_wdata[ssu_pkg::CSR_HALVE];
            end
            change_q <= change_ev || (change_q && !(wr_csr && reg_wdata[ssu_pkg::CSR_CHANGE]));
            underrun_q <= (tx_reload && tx_dry) ||
                          (underrun_q && !(wr_csr && reg_wdata[ssu_pkg::CSR_TX_UNDERRUN]));
            overrun_q <= rx_overrun_ev ||
                         (overrun_q && !(wr_csr && reg_wdata[ssu_pkg::CSR_RX_OVERRUN]));
        end
    end

    // single-domain edge sampling keeps every event counted once
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            // follow the pins in reset so no false edge shows after release
            pin1_prev_q <= dual_pin_one_in;
            tx_clk_prev_q <= tx_clk;
            rx_clk_prev_q <= rx_serial_clock_pin;
            half_clk_q <= 1'b0;
        end else begin
            pin1_prev_q <= dual_pin_one_in;
            tx_clk_prev_q <= tx_clk;
            rx_clk_prev_q <= rx_serial_clock_pin;
            if (rx_rise) begin
                half_clk_q <= !half_clk_q;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            gen_bit_q <= 4'h0;
            gen_slot_q <= 4'h0;
            gen_fs_q <= 1'b0;
        end else begin
            gen_fs_q <= gen_fs_d;
            if (tx_edge) begin
                gen_bit_q <= gen_bit_q + 4'h1;
                if (gen_bit_q == ssu_pkg::BIT_LAST) begin
                    gen_slot_q <= (gen_slot_q == slot_last) ? 4'h0 : gen_slot_q + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            tx_state_q <= ssu_pkg::TX_IDLE;
            tx_sr_q <= 16'h0000;
            tx_last_q <= 16'h0000;
            tx_cnt_q <= 4'h0;
            tx_serial_data_pin <= 1'b0;
        end else if (!transmitter_enable) begin
            tx_state_q <= ssu_pkg::TX_IDLE;
        end else if (tx_reload) begin
            tx_state_q <= ssu_pkg::TX_SHIFT;
            tx_last_q <= tx_load;
            tx_sr_q <= shift_out(tx_load, tx_shift_direction);
            tx_cnt_q <= 4'h1;
            tx_serial_data_pin <= first_bit(tx_load, tx_shift_direction);
        end else if (tx_edge) begin
            case (tx_state_q)
                ssu_pkg::TX_SHIFT: begin
                    tx_sr_q <= shift_out(tx_sr_q, tx_shift_direction);
                    tx_cnt_q <= tx_cnt_q + 4'h1;
                    tx_serial_data_pin <= first_bit(tx_sr_q, tx_shift_direction);
                end
                ssu_pkg::TX_IDLE: begin
                    tx_cnt_q <= 4'h0;
                end
                default: begin
                    tx_state_q <= ssu_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // second half follows one clock after the first
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            pend_q <= 1'b0;
            pend_data_q <= 16'h0000;
        end else begin
            pend_q <= txdr_ok && !pend_q;
            if (txdr_ok && !pend_q) begin
                pend_data_q <= tx_second;
            end
        end
    end

    // receive shifter, frame sync starts a word
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            rx_sr_q <= 16'h0000;
            rx_cnt_q <= 4'h0;
            rx_active_q <= 1'b0;
        end else if (!rxe) begin
            rx_active_q <= 1'b0;
            rx_cnt_q <= 4'h0;
        end else if (rx_take) begin
            rx_sr_q <= rx_next;
            rx_cnt_q <= (rx_active_q ? rx_cnt_q : 4'h0) + 4'h1;
            rx_active_q <= !rx_done || rx_frame_sync_pin;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            pin1_out_q <= 1'b0;
            pin2_out_q <= 1'b0;
            pin1_oe_n_q <= 1'b1;
            pin2_oe_n_q <= 1'b1;
        end else begin
            pin1_out_q <= ctl_q[ssu_pkg::CTL_PIN1_OUT];
            pin1_oe_n_q <= (pin1_sel != ssu_pkg::SEL_GP_OUT);
            pin2_out_q <= (pin2_sel == ssu_pkg::SEL_FUNC_A) ? gen_fs_q : ctl_q[ssu_pkg::CTL_PIN2_OUT];
            pin2_oe_n_q <= (pin2_sel != ssu_pkg::SEL_GP_OUT) && (pin2_sel != ssu_pkg::SEL_FUNC_A);
        end
    end
    assign dual_pin_one_out = pin1_out_q;
    assign dual_pin_one_oe_n = pin1_oe_n_q;
    assign dual_pin_two_out = pin2_out_q;
    assign dual_pin_two_oe_n = pin2_oe_n_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 32'h00000000;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_read;
            if (reg_read) begin
                reg_rdata <= rd_mux;
            end
        end
    end
endmodule : ssu_serial_port
`default_nettype wire

// [include/ssu_pkg.sv]
package ssu_pkg;
    // register offsets on the highway port
    localparam logic [7:0] OFF_CTL = 8'h00;
    localparam logic [7:0] OFF_CSR = 8'h04;
    localparam logic [7:0] OFF_TXDR = 8'h08;
    localparam logic [7:0] OFF_RXDR = 8'h0C;
    localparam logic [7:0] OFF_RXACK = 8'h10;
    // port_control_register field positions
    localparam int CTL_PIN1_SEL = 0;
    localparam int CTL_PIN2_SEL = 2;
    localparam int CTL_PIN1_OUT = 4;
    localparam int CTL_PIN2_OUT = 5;
    localparam int CTL_CDE = 6;
    localparam int CTL_FMS = 7;
    localparam int CTL_TCP = 8;
    localparam int CTL_RCP = 9;
    localparam int CTL_TSD = 10;
    localparam int CTL_RSD = 11;
    localparam int CTL_SLOTS = 12;
    localparam int CTL_TXE = 16;
    localparam int CTL_RXE = 17;
    localparam int CTL_EMS = 18;
    localparam int CTL_TXR = 19;
    localparam int CTL_RXR = 20;
    localparam logic [31:0] CTL_STORE_MASK = 32'h0007FFFF;
    localparam logic [31:0] CTL_RESET = 32'h0000000F;
    // port_status_register field positions
    localparam int CSR_HALVE = 0;
    localparam int CSR_PIN1_IN = 1;
    localparam int CSR_PIN2_IN = 2;
    localparam int CSR_CHANGE = 3;
    localparam int CSR_TX_UNDERRUN = 4;
    localparam int CSR_RX_OVERRUN = 5;
    localparam int CSR_WAR = 8;
    localparam int CSR_TX_FREE = 16;
    localparam logic CSR_HALVE_RESET = 1'b0;
    // pin select codes
    localparam logic [1:0] SEL_GP_OUT = 2'b00;
    localparam logic [1:0] SEL_GP_IN = 2'b01;
    localparam logic [1:0] SEL_FUNC_A = 2'b10;
    localparam logic [1:0] SEL_FUNC_B = 2'b11;
    // buffer geometry
    localparam int WORD_W = 16;
    localparam int CNT_W = 6;
    localparam int TX_DEPTH = 30;
    localparam int RX_DEPTH = 32;
    localparam logic [3:0] BIT_LAST = 4'hF;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } ssu_tx_state_t;
endpackage : ssu_pkg

// [include/ssu_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ssu_fifo_if;
    logic push;
    logic [15:0] push_data;
    logic pop;
    logic pop2;
    logic [15:0] head0;
    logic [15:0] head1;
    logic [5:0] count;
    logic full;
    logic empty;
    modport store (input push, push_data, pop, pop2, output head0, head1, count, full, empty);
    modport user (output push, push_data, pop, pop2, input head0, head1, count, full, empty);
endinterface : ssu_fifo_if
`default_nettype wire

// [verilog/ssu_word_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module ssu_word_fifo #(
    parameter int unsigned DEPTH = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // storage side
    ssu_fifo_if.store port
);
    logic [15:0] mem_q [DEPTH];
    logic [4:0] rd_q;
    logic [4:0] wr_q;
    logic [5:0] cnt_q;
    logic do_push;
    logic [1:0] n_pop;

    function automatic logic [4:0] ptr_add(input logic [4:0] p, input logic [1:0] inc);
        logic [5:0] s;
        s = {1'b0, p} + {4'h0, inc};
        if (s >= 6'(DEPTH)) begin
            s = s - 6'(DEPTH);
        end
        return s[4:0];
    endfunction : ptr_add

    // a push into a full buffer is dropped, the caller checks full first
    assign do_push = port.push && (cnt_q != 6'(DEPTH));
    assign n_pop = (port.pop2 && cnt_q >= 6'h02) ? 2'h2 : (port.pop && cnt_q != 6'h00) ? 2'h1 : 2'h0;
    assign port.head0 = mem_q[rd_q];
    assign port.head1 = mem_q[ptr_add(rd_q, 2'h1)];
    assign port.count = cnt_q;
    assign port.full = (cnt_q == 6'(DEPTH));
    assign port.empty = (cnt_q == 6'h00);

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem_q[wr_q] <= port.push_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_q <= 5'h00;
            wr_q <= 5'h00;
            cnt_q <= 6'h00;
        end else begin
            rd_q <= ptr_add(rd_q, n_pop);
            wr_q <= ptr_add(wr_q, {1'b0, do_push});
            cnt_q <= cnt_q + {5'h00, do_push} - {4'h0, n_pop};
        end
    end
endmodule : ssu_word_fifo
`default_nettype wire

// [bench/ssu_serial_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ssu_serial_port_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rdata_valid,
    // pins
    input wire logic dual_pin_one_out,
    input wire logic dual_pin_one_oe_n,
    input wire logic dual_pin_two_out,
    input wire logic dual_pin_two_oe_n,
    input wire logic change_detect_request
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    logic ctl_wr;
    logic rx_rd;
    // transmitter reset left out, it overrides both selects
    assign ctl_wr = reg_write && reg_addr == ssu_pkg::OFF_CTL && !reg_wdata[ssu_pkg::CTL_TXR];
    assign rx_rd = reg_read && reg_addr == ssu_pkg::OFF_RXDR;
    read_answer_a: assert property (reg_read |=> reg_rdata_valid)
        else $error("read got no answer");
    quiet_valid_a: assert property (!reg_read |=> !reg_rdata_valid)
        else $error("answer without read");
    pin1_drive_a: assert property (ctl_wr && reg_wdata[1:0] == ssu_pkg::SEL_GP_OUT |->
        ##2 !dual_pin_one_oe_n && dual_pin_one_out == $past(reg_wdata[ssu_pkg::CTL_PIN1_OUT], 2))
        else $error("pin one not driven");
    pin1_float_a: assert property (ctl_wr && reg_wdata[1] |-> ##2 dual_pin_one_oe_n)
        else $error("pin one driven as input");
    pin2_drive_a: assert property (ctl_wr && reg_wdata[3:2] == ssu_pkg::SEL_GP_OUT |->
        ##2 !dual_pin_two_oe_n && dual_pin_two_out == $past(reg_wdata[ssu_pkg::CTL_PIN2_OUT], 2))
        else $error("pin two not driven");
    sync_out_a: assert property (ctl_wr && reg_wdata[3:2] == ssu_pkg::SEL_FUNC_A |->
        ##2 !dual_pin_two_oe_n)
        else $error("sync output not driven");
    pin2_float_a: assert property (ctl_wr && reg_wdata[2] |-> ##2 dual_pin_two_oe_n)
        else $error("pin two driven as input");
    txr_float_a: assert property (
        reg_write && reg_addr == ssu_pkg::OFF_CTL && reg_wdata[ssu_pkg::CTL_TXR]
        |-> ##2 dual_pin_one_oe_n && dual_pin_two_oe_n)
        else $error("pins driven after transmitter reset");
    rx_peek_a: assert property (
        rx_rd ##1 (!reg_read && !reg_write) ##1 rx_rd |=> reg_rdata == $past(reg_rdata, 2))
        else $error("receive word moved by a read");
    ack_read_a: assert property (reg_read && reg_addr == ssu_pkg::OFF_RXACK |=>
        reg_rdata == 32'h00000000)
        else $error("acknowledge read not zero");
    irq_gate_a: assert property (ctl_wr && !reg_wdata[ssu_pkg::CTL_CDE] |->
        ##2 !change_detect_request)
        else $error("request with enable off");
    cover property (rx_rd);
    cover property (change_detect_request);
    cover property (ctl_wr ##2 !dual_pin_one_oe_n);
endmodule : ssu_serial_port_assertions
bind ssu_serial_port ssu_serial_port_assertions chk (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .dual_pin_one_out(dual_pin_one_out),
    .dual_pin_one_oe_n(dual_pin_one_oe_n), .dual_pin_two_out(dual_pin_two_out),
    .dual_pin_two_oe_n(dual_pin_two_oe_n), .change_detect_request(change_detect_request)
);
`default_nettype wire

// [bench/ssu_codec_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssu_codec_model #(
    parameter int HALF_NS = 320
) (
    // link toward the port
    output logic rx_clk,
    output logic rx_sync,
    output logic rx_data,
    input wire logic tx_data,
    // last word heard from the port
    output logic [15:0] tx_word
);
    initial begin
        rx_clk = 1'b0;
        rx_sync = 1'b0;
        rx_data = 1'b0;
        tx_word = 16'h0000;
    end
    task automatic send(input logic [15:0] w);
        logic [15:0] cap;
        cap = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            rx_data = w[i];
            rx_sync = (i == 15);
            #(HALF_NS);
            rx_clk = 1'b1;
            #(HALF_NS);
            rx_clk = 1'b0;
            cap = {cap[14:0], tx_data};
        end
        tx_word = cap;
    endtask : send
    // falling-edge partner, data moves on rise
    task automatic send_fall(input logic [15:0] w);
        logic [15:0] cap;
        cap = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            rx_clk = 1'b1;
            rx_data = w[i];
            rx_sync = (i == 15);
            #(HALF_NS);
            rx_clk = 1'b0;
            #(HALF_NS);
            cap = {cap[14:0], tx_data};
        end
        tx_word = cap;
    endtask : send_fall
    // released line must not keep the last bit
    task automatic idle();
        rx_data = ~rx_data;
    endtask : idle
endmodule : ssu_codec_model
`default_nettype wire

// [bench/sync_serial_codec_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_serial_codec_port_test;
    logic ref_clk;
    logic srst;
    logic [7:0] reg_addr;
    logic reg_write;
    logic reg_read;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_rdata_valid;
    logic rx_clk, rx_sync, rx_data, tx_data, req;
    logic p1_out, p1_oe_n, p2_out, p2_oe_n, p1_drv, p2_drv;
    logic [15:0] tx_word;
    logic [31:0] d;
    int n_mismatch;
    int comparisons;
    // pin level: device while it drives, else the bench
    wire p1_wire = !p1_oe_n ? p1_out : p1_drv;
    wire p2_wire = !p2_oe_n ? p2_out : p2_drv;
    ssu_serial_port dut (
        .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .rx_serial_clock_pin(rx_clk),
        .rx_frame_sync_pin(rx_sync), .rx_serial_data_pin(rx_data),
        .tx_serial_data_pin(tx_data), .dual_pin_one_in(p1_wire), .dual_pin_one_out(p1_out),
        .dual_pin_one_oe_n(p1_oe_n), .dual_pin_two_in(p2_wire), .dual_pin_two_out(p2_out),
        .dual_pin_two_oe_n(p2_oe_n), .change_detect_request(req)
    );
    ssu_codec_model codec (
        .rx_clk(rx_clk), .rx_sync(rx_sync), .rx_data(rx_data), .tx_data(tx_data),
        .tx_word(tx_word)
    );
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        #2;
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1'b1;
        @(posedge ref_clk);
        #2;
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        #2;
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge ref_clk);
        #2;
        reg_read = 1'b0;
        v = reg_rdata;
    endtask : rd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // whole run needs about 0.4 ms
    initial begin
        #1000000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 32'h00000000;
        p1_drv = 1'b1;
        p2_drv = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (8) @(posedge ref_clk);
        #2;
        srst = 1'b0;
        rd(ssu_pkg::OFF_CTL, d);
        chk(d, ssu_pkg::CTL_RESET);
        rd(ssu_pkg::OFF_CSR, d);
        chk(d & 32'h003F1F31, 32'h001E0000);
        chk({30'h0, p1_oe_n, p2_oe_n}, 32'h00000003);
        rd(8'h14, d);
        chk(d, 32'h00000000);
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            wr(ssu_pkg::OFF_CTL, 32'h00000030 | 32'(c * 5));
            repeat (2) @(posedge ref_clk);
            #2;
            chk({30'h0, p1_oe_n, p2_oe_n}, {30'h0, c != 0, c[0]});
        end
        wr(ssu_pkg::OFF_CTL, 32'h00000045);
        wr(ssu_pkg::OFF_CSR, 32'h00000008);
        chk({31'h0, req}, 32'h00000000);
        rd(ssu_pkg::OFF_CSR, d);
        chk((d >> 1) & 32'h00000003, 32'h00000001);
        p1_drv = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({31'h0, req}, 32'h00000001);
        wr(ssu_pkg::OFF_CSR, 32'h00000008);
        chk({31'h0, req}, 32'h00000000);
        wr(ssu_pkg::OFF_CTL, 32'h00080000);
        rd(ssu_pkg::OFF_CTL, d);
        chk(d, 32'h0000000F);
        $display("pin test done");
        wr(ssu_pkg::OFF_CTL, 32'h00180000);
        wr(ssu_pkg::OFF_CTL, 32'h00070003);
        wr(ssu_pkg::OFF_TXDR, 32'h1234ABCD);
        codec.send(16'hC3A5);
        chk({16'h0, tx_word}, 32'h0000ABCD);
        codec.send(16'h0FF0);
        codec.idle();
        chk({16'h0, tx_word}, 32'h00001234);
        rd(ssu_pkg::OFF_CSR, d);
        chk(d & 32'h00001F00, 32'h00000100);
        rd(ssu_pkg::OFF_RXDR, d);
        chk(d, 32'h0FF0C3A5);
        rd(ssu_pkg::OFF_RXDR, d);
        chk(d, 32'h0FF0C3A5);
        wr(ssu_pkg::OFF_RXACK, 32'h00000000);
        rd(ssu_pkg::OFF_CSR, d);
        chk(d & 32'h00001F00, 32'h00000100);
        wr(ssu_pkg::OFF_RXACK, 32'h00000001);
        rd(ssu_pkg::OFF_CSR, d);
        chk(d & 32'h00001F00, 32'h00000000);
        rd(ssu_pkg::OFF_RXACK, d);
        chk(d, 32'h00000000);
        codec.send(16'h5AA5);
        codec.idle();
        chk({16'h0, tx_word}, 32'h00001234);
        rd(ssu_pkg::OFF_CSR, d);
        chk(d & 32'h00000010, 32'h00000010);
        for (int i = 0; i < 32; i++) begin
            codec.send(16'(i));
        end
        codec.idle();
        rd(ssu_pkg::OFF_CSR, d);
        chk(d & 32'h00001F20, 32'h00001020);
        $display("stream test done");
        wr(ssu_pkg::OFF_CTL, 32'h00180000);
        wr(ssu_pkg::OFF_CTL, 32'h00030F0B);
        wr(ssu_pkg::OFF_TXDR, 32'h1234ABCD);
        codec.send_fall(16'h00FF);
        chk({16'h0, tx_word}, 32'h00002C48);
        codec.send_fall(16'h0F0F);
        codec.idle();
        chk({16'h0, tx_word}, 32'h0000B3D5);
        rd(ssu_pkg::OFF_RXDR, d);
        chk(d, 32'hFF00F0F0);
        chk({30'h0, p2_oe_n, p2_out}, 32'h00000000);
        $display("polarity test done");
        end_of_test();
    end
endmodule : sync_serial_codec_port_test
`default_nettype wire
